// file: inc/hypcfg_pkg.sv
// Package with encodings, field positions and reset values of the hypervisor configuration block
package hypcfg_pkg;
    // ==========================================================
    // System register access encoding
    localparam logic [3:0] HYPCFG_COPROC = 4'hF;
    localparam logic [2:0] HYPCFG_OPC1 = 3'h4;
    localparam logic [3:0] HYPCFG_CRN = 4'h1;
    localparam logic [3:0] HYPCFG_CRM = 4'h1;
    localparam logic [2:0] HYPCFG_OPC2_MAIN = 3'h0;
    localparam logic [2:0] HYPCFG_OPC2_SECOND = 3'h4;
    // ==========================================================
    // Main register field positions
    localparam int HYPCFG_BSU_LSB = 10;
    localparam int HYPCFG_FB_BIT = 9;
    localparam int HYPCFG_VA_BIT = 8;
    localparam int HYPCFG_VI_BIT = 7;
    localparam int HYPCFG_VF_BIT = 6;
    localparam int HYPCFG_AMO_BIT = 5;
    localparam int HYPCFG_IMO_BIT = 4;
    localparam int HYPCFG_FMO_BIT = 3;
    localparam int HYPCFG_SETWAY_INVAL_OVERRIDE_BIT = 1;
    localparam int HYPCFG_VM_BIT = 0;
    // Second register field position
    localparam int HYPCFG_MIOC_BIT = 6;
    // ==========================================================
    // Writable masks and reset values
    localparam logic [31:0] HYPCFG_MAIN_MASK = 32'h00000FFB;
    localparam logic [31:0] HYPCFG_SECOND_MASK = 32'h00000040;
    localparam logic [31:0] HYPCFG_MAIN_RESET = 32'h00000000;
    localparam logic [31:0] HYPCFG_SECOND_RESET = 32'h00000000;
    // ==========================================================
    // Exception levels and shareability encodings
    localparam logic [1:0] HYPCFG_EL0 = 2'h0;
    localparam logic [1:0] HYPCFG_EL1 = 2'h1;
    localparam logic [1:0] HYPCFG_EL2 = 2'h2;
    localparam logic [1:0] HYPCFG_SH_NONE = 2'h0;
    localparam logic [1:0] HYPCFG_SH_INNER = 2'h1;
    localparam logic [1:0] HYPCFG_SH_OUTER = 2'h2;
    localparam logic [1:0] HYPCFG_SH_SYSTEM = 2'h3;
endpackage : hypcfg_pkg

// file: hw/hypcfg_top.sv
// Hypervisor configuration registers and their decoded controls
//
// Notes on behaviour
// - Upgrade field sets least barrier shareability
// - Merged barrier level is the wider domain
// - Force broadcast of EL1 predictor/icache invalidates
// - Guest SError pending bit raises virtual SError
// - Virtual SError only when trap off, override on
// - Guest IRQ pending gated by trap and override
// - Guest FIQ pending gated by trap and override
// - SError override ignores physical mask, enables virtual
// - IRQ override ignores physical mask, enables virtual
// - FIQ override ignores physical mask, enables virtual
// - Trap-general is tied low here, so overrides are never forced; reads stay stored
// - Virtual exceptions share the physical outputs, taken only outside hyp and when unmasked
// - Set/way override turns invalidate into clean+invalidate
// - Stage 2 protection enable for EL1/EL0
// - Default cacheable bit 12 is not writable, so it never forces stage 2
// - Stage 2 on: EL1 data invalidates also clean
// - Main register fields reset to zero
// - Main register at opc1 4, opc2 0, c1, c1
// - Second register at opc1 4, opc2 4, c1, c1
// - Both registers accessible only from EL2
// - EL1 main register access traps to hyp when crn1 trap set and EL2 present
// - Mismatched cacheability non-coherency enable bit
`timescale 1ns/1ps
`default_nettype none
module hypcfg_top
    import hypcfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    // Coprocessor access port
    input wire logic cp_valid,
    input wire logic cp_write,
    input wire logic [3:0] cp_coproc,
    input wire logic [2:0] cp_opc1,
    input wire logic [2:0] cp_opc2,
    input wire logic [3:0] cp_crn,
    input wire logic [3:0] cp_crm,
    input wire logic [31:0] cp_wdata,
    input wire logic [1:0] cur_el,
    input wire logic el2_present,
    input wire logic trap_crn1,
    output logic cp_hit,
    output logic cp_undef,
    output logic cp_trap_hyp,
    output logic [31:0] cp_rdata_ff,
    // Exception inputs
    input wire logic in_hyp_mode,
    input wire logic phys_serror,
    input wire logic phys_irq,
    input wire logic phys_fiq,
    input wire logic status_a_mask,
    input wire logic status_i_mask,
    input wire logic status_f_mask,
    output logic take_serror,
    output logic take_irq,
    output logic take_fiq,
    // Barrier and maintenance decode
    input wire logic [1:0] barrier_sh_req,
    output logic [1:0] barrier_sh_eff,
    input wire logic inval_all_op,
    output logic inval_all_broadcast,
    input wire logic dc_inv_op,
    input wire logic dc_inv_is_setway,
    output logic dc_inv_do_clean,
    // Translation controls
    output logic stage2_active,
    output logic mismatch_noncoherent
);
    // ==========================================================
    // Reset release
    logic rst_meta_ff;
    logic rst_sync_ff;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    // ==========================================================
    // Access decode
    logic enc_common;
    logic sel_main;
    logic sel_second;
    logic low_el;
    assign enc_common = cp_valid && cp_coproc == HYPCFG_COPROC &&
        cp_opc1 == HYPCFG_OPC1 && cp_crn == HYPCFG_CRN &&
        cp_crm == HYPCFG_CRM;
    assign sel_main = enc_common && cp_opc2 == HYPCFG_OPC2_MAIN;
    assign sel_second = enc_common &&
        cp_opc2 == HYPCFG_OPC2_SECOND;
    assign low_el = cur_el != HYPCFG_EL2;
    // Hyp trap of EL1 outranks the undefined answer at EL1
    assign cp_trap_hyp = sel_main && cur_el == HYPCFG_EL1 &&
        el2_present && trap_crn1;
    assign cp_undef = (sel_main || sel_second) && low_el &&
        !cp_trap_hyp;
    assign cp_hit = (sel_main || sel_second) && !low_el;
    // ==========================================================
    // Register state
    logic [31:0] main_ff;
    logic [31:0] second_ff;
    logic [31:0] nxt_main;
    logic [31:0] nxt_second;
    logic [31:0] nxt_rdata;
    logic trap_general_exceptions;
    always_comb begin
        nxt_main = main_ff;
        nxt_second = second_ff;
        nxt_rdata = cp_rdata_ff;
        if (cp_hit && cp_write && sel_main) begin
            nxt_main = cp_wdata & HYPCFG_MAIN_MASK;
        end
        if (cp_hit && cp_write && sel_second) begin
            nxt_second = cp_wdata & HYPCFG_SECOND_MASK;
        end
        // Reads return stored bits, never the forced behaviour
        if (cp_hit && !cp_write) begin
            nxt_rdata = sel_main ? main_ff : second_ff;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            main_ff <= HYPCFG_MAIN_RESET;
            second_ff <= HYPCFG_SECOND_RESET;
            cp_rdata_ff <= 32'h00000000;
        end else begin
            main_ff <= nxt_main;
            second_ff <= nxt_second;
            cp_rdata_ff <= nxt_rdata;
        end
    end
    // Trap-general lives in the upper half, handled elsewhere
    assign trap_general_exceptions = 1'b0;
    // ==========================================================
    // Exception gating
    logic amo_eff;
    logic imo_eff;
    logic fmo_eff;
    logic virt_serror;
    logic virt_irq;
    logic virt_fiq;
    assign amo_eff = main_ff[HYPCFG_AMO_BIT] || trap_general_exceptions;
    assign imo_eff = main_ff[HYPCFG_IMO_BIT] || trap_general_exceptions;
    assign fmo_eff = main_ff[HYPCFG_FMO_BIT] || trap_general_exceptions;
    assign virt_serror = main_ff[HYPCFG_VA_BIT] && !trap_general_exceptions &&
        main_ff[HYPCFG_AMO_BIT];
    assign virt_irq = main_ff[HYPCFG_VI_BIT] && !trap_general_exceptions &&
        main_ff[HYPCFG_IMO_BIT];
    assign virt_fiq = main_ff[HYPCFG_VF_BIT] && !trap_general_exceptions &&
        main_ff[HYPCFG_FMO_BIT];
    // Virtual and physical share one output so guests cannot tell them apart
    // Virtual ones only reach a guest, never hyp mode
    assign take_serror = (phys_serror && (amo_eff || !status_a_mask)) ||
        (virt_serror && !in_hyp_mode && !status_a_mask);
    assign take_irq = (phys_irq && (imo_eff || !status_i_mask)) ||
        (virt_irq && !in_hyp_mode && !status_i_mask);
    assign take_fiq = (phys_fiq && (fmo_eff || !status_f_mask)) ||
        (virt_fiq && !in_hyp_mode && !status_f_mask);
    // ==========================================================
    // Barrier and cache maintenance
    logic [1:0] barrier_share_upgrade;
    logic el1_op;
    assign barrier_share_upgrade = main_ff[HYPCFG_BSU_LSB +: 2];
    assign el1_op = cur_el == HYPCFG_EL1;
    always_comb begin
        // Outside EL2 the wider of the two domains wins; codes rise with width
        barrier_sh_eff = barrier_sh_req;
        if (!low_el) begin
            barrier_sh_eff = barrier_sh_req;
        end else if (barrier_share_upgrade > barrier_sh_req) begin
            barrier_sh_eff = barrier_share_upgrade;
        end
    end
    assign inval_all_broadcast = inval_all_op && el1_op &&
        main_ff[HYPCFG_FB_BIT];
    assign stage2_active = !in_hyp_mode && (main_ff[HYPCFG_VM_BIT] ||
        main_ff[12]);
    assign dc_inv_do_clean = dc_inv_op && el1_op &&
        (stage2_active || (dc_inv_is_setway &&
        main_ff[HYPCFG_SETWAY_INVAL_OVERRIDE_BIT]));
    assign mismatch_noncoherent = second_ff[HYPCFG_MIOC_BIT];
endmodule : hypcfg_top
`default_nettype wire

// file: tb/hypcfg_checker.sv
// Port-level assertions for the hypervisor configuration block
`timescale 1ns/1ps
`default_nettype none
module hypcfg_checker
    import hypcfg_pkg::*;
(
    input wire logic ref_clk, rst_b, cp_valid, cp_write,
    input wire logic [2:0] cp_opc2,
    input wire logic [31:0] cp_wdata, cp_rdata_ff,
    input wire logic [1:0] cur_el, barrier_sh_req, barrier_sh_eff,
    input wire logic el2_present, trap_crn1, cp_hit, cp_undef, cp_trap_hyp,
    input wire logic stage2_active, mismatch_noncoherent
);
    // ==========================================================
    // Sequences and assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_sec_write;
        cp_valid && cp_hit && cp_write && cp_opc2 == HYPCFG_OPC2_SECOND;
    endsequence
    a_hit_el2_only: assert property (cp_hit |-> cur_el == HYPCFG_EL2)
        else $error("access accepted below hypervisor level");
    a_hit_not_refused: assert property (cp_hit |-> !cp_undef && !cp_trap_hyp)
        else $error("accepted access also refused");
    a_trap_cause: assert property (cp_trap_hyp |-> cur_el == HYPCFG_EL1
        && el2_present && trap_crn1 && cp_opc2 == HYPCFG_OPC2_MAIN)
        else $error("hyp trap without its cause");
    a_rdata_holds: assert property (!(cp_valid && cp_hit && !cp_write)
        |=> $stable(cp_rdata_ff)) else $error("read data moved");
    a_rsvd_zero: assert property (cp_rdata_ff[2] == 1'h0
        && cp_rdata_ff[31:12] == 20'h00000) else $error("reserved bit read set");
    a_barrier_wider: assert property (barrier_sh_eff >= barrier_sh_req)
        else $error("barrier domain narrowed");
    a_barrier_hyp: assert property (cur_el == HYPCFG_EL2
        |-> barrier_sh_eff == barrier_sh_req) else $error("upgrade at EL2");
    a_second_write: assert property (s_sec_write
        |=> mismatch_noncoherent == $past(cp_wdata[HYPCFG_MIOC_BIT]))
        else $error("coherency control not updated");
    // Checked while reset is low, so the default disable is overridden
    a_reset_clear: assert property (disable iff (1'h0) !rst_b
        |-> !stage2_active && !mismatch_noncoherent)
        else $error("controls active in reset");
endmodule : hypcfg_checker
bind hypcfg_top hypcfg_checker hypcfg_checker_i (.*);
`default_nettype wire

// file: tb/hyp_virtualization_config_tb_top.sv
// Self-checking bench for the hypervisor configuration block
`timescale 1ns/1ps
`default_nettype none
module hyp_virtualization_config_tb_top;
    import hypcfg_pkg::*;
    logic ref_clk = 1'h0, rst_b = 1'h1, cp_valid = 1'h0, cp_write = 1'h0;
    logic [3:0] cp_coproc = HYPCFG_COPROC, cp_crn = HYPCFG_CRN;
    logic [3:0] cp_crm = HYPCFG_CRM;
    logic [2:0] cp_opc1 = HYPCFG_OPC1, cp_opc2 = 3'h0;
    logic [31:0] cp_wdata = 32'h0, cp_rdata_ff;
    logic [1:0] cur_el = HYPCFG_EL2, barrier_sh_req = 2'h0, barrier_sh_eff;
    logic el2_present = 1'h1, trap_crn1 = 1'h0, in_hyp_mode = 1'h0;
    logic phys_serror = 1'h0, phys_irq = 1'h0, phys_fiq = 1'h0;
    logic status_a_mask = 1'h0, status_i_mask = 1'h0, status_f_mask = 1'h0;
    logic inval_all_op = 1'h0, dc_inv_op = 1'h0, dc_inv_is_setway = 1'h0;
    logic cp_hit, cp_undef, cp_trap_hyp, take_serror, take_irq, take_fiq;
    logic inval_all_broadcast, dc_inv_do_clean, stage2_active;
    logic mismatch_noncoherent, h, u, t;
    int miscompares = 0, total_checks = 0, cyc = 0;
    hypcfg_top hypcfg_top_i (.*);
    // ==========================================================
    // Clock, timeout and shared tasks
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Starts at the next falling edge; request held over one rising edge
    task automatic acc(input logic w, input logic [1:0] el,
        input logic [2:0] o2, input logic [31:0] d);
        @(negedge ref_clk);
        {cp_valid, cp_write, cur_el, cp_opc2, cp_wdata} = {1'h1, w, el, o2, d};
        #1 {h, u, t} = {cp_hit, cp_undef, cp_trap_hyp};
        @(negedge ref_clk);
        cp_valid = 1'h0;
        cur_el = HYPCFG_EL2;
    endtask : acc
    // ==========================================================
    // Scenarios
    task automatic t_regs();
        acc(0, HYPCFG_EL2, HYPCFG_OPC2_MAIN, 0);
        chk("main reset", cp_rdata_ff, 32'h0);
        acc(1, HYPCFG_EL2, HYPCFG_OPC2_MAIN, '1);
        acc(0, HYPCFG_EL2, HYPCFG_OPC2_MAIN, 0);
        chk("main ones", cp_rdata_ff, 32'h00000FFB);
        acc(1, HYPCFG_EL2, HYPCFG_OPC2_SECOND, '1);
        chk("mismatch bit", mismatch_noncoherent, 1'h1);
        acc(0, HYPCFG_EL2, HYPCFG_OPC2_SECOND, 0);
        chk("second ones", cp_rdata_ff, 32'h00000040);
        acc(1, HYPCFG_EL2, HYPCFG_OPC2_SECOND, 0);
        acc(1, HYPCFG_EL2, HYPCFG_OPC2_MAIN, 0);
        // Low levels must leave the cleared registers untouched
        trap_crn1 = 1'h1;
        acc(1, HYPCFG_EL1, HYPCFG_OPC2_MAIN, '1);
        chk("el1 trap", {h, t}, 2'h1);
        trap_crn1 = 1'h0;
        acc(1, HYPCFG_EL0, HYPCFG_OPC2_SECOND, '1);
        chk("el0 undef", {h, u}, 2'h1);
        acc(0, HYPCFG_EL2, HYPCFG_OPC2_MAIN, 0);
        chk("main kept", cp_rdata_ff, 32'h0);
        $display("registers and access test done");
    endtask : t_regs
    task automatic t_barrier();
        for (int b = 0; b < 4; b++) begin
            acc(1, HYPCFG_EL2, HYPCFG_OPC2_MAIN, 32'(b) << HYPCFG_BSU_LSB);
            cur_el = HYPCFG_EL1;
            for (int r = 0; r < 4; r++) begin
                @(negedge ref_clk);
                barrier_sh_req = 2'(r);
                #1 chk("barrier", barrier_sh_eff, (b > r) ? b : r);
            end
        end
        $display("barrier test done");
    endtask : t_barrier
    task automatic t_virt();
        for (int k = 0; k < 3; k++) begin
            for (int m = 1; m < 4; m++) begin
                acc(1, HYPCFG_EL2, HYPCFG_OPC2_MAIN,
                    ((m & 1) << (8 - k)) | ((m >> 1) << (5 - k)));
                cur_el = HYPCFG_EL1;
                #1 chk("virtual", {take_fiq, take_irq, take_serror} >> k, m == 3);
            end
        end
        {phys_irq, status_i_mask} = 2'h3;
        acc(1, HYPCFG_EL2, HYPCFG_OPC2_MAIN, 32'h00000010);
        #1 chk("irq override", take_irq, 1'h1);
        {phys_irq, status_i_mask} = 2'h0;
        $display("virtual exception test done");
    endtask : t_virt
    task automatic t_maint();
        acc(1, HYPCFG_EL2, HYPCFG_OPC2_MAIN, 32'h00000202);
        {inval_all_op, dc_inv_op, dc_inv_is_setway, cur_el} = 5'h1D;
        #1 chk("bcast clean", {inval_all_broadcast, dc_inv_do_clean}, 2'h3);
        acc(1, HYPCFG_EL2, HYPCFG_OPC2_MAIN, 32'h00000001);
        {dc_inv_is_setway, cur_el} = 3'h1;
        #1 chk("stage2 clean", {stage2_active, dc_inv_do_clean}, 2'h3);
        chk("no bcast", inval_all_broadcast, 1'h0);
        $display("maintenance test done");
    endtask : t_maint
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    initial begin
        // Real falling edge of reset, so the asynchronous clears fire
        #1 rst_b = 1'h0;
        repeat (8) @(negedge ref_clk);
        rst_b = 1'h1;
        repeat (3) @(negedge ref_clk);
        t_regs();
        t_barrier();
        t_virt();
        t_maint();
        conclude();
    end
endmodule : hyp_virtualization_config_tb_top
`default_nettype wire
